//--- rtl/sbdp_pkg.sv
// package for the serial baud and data path: register indices, field
// positions, reset values and oversampling constants.
// assumes a 32-bit classic wishbone slave with word-aligned registers.
package sbdp_pkg;

   // ****************************************************************
   // register indices (byte address is four times the index)
   // ****************************************************************
   localparam logic [7:0] SBDP_IDX_STATUS = 8'hF0;
   localparam logic [7:0] SBDP_IDX_DATA   = 8'hF1;
   localparam logic [7:0] SBDP_IDX_BAUD   = 8'hF2;
   localparam logic [7:0] SBDP_IDX_RXFINE = 8'hF5;
   localparam logic [7:0] SBDP_IDX_TXFINE = 8'hF6;
   localparam int         SBDP_ADR_W      = 10;

   // ****************************************************************
   // baud_select fields
   // ****************************************************************
   localparam int SBDP_FSEL_HI = 7;
   localparam int SBDP_FSEL_LO = 6;
   localparam int SBDP_TXC_HI  = 5;
   localparam int SBDP_TXC_LO  = 3;
   localparam int SBDP_RXC_HI  = 2;
   localparam int SBDP_RXC_LO  = 0;

   // first stage divide factors for codes 00, 01, 10, 11
   localparam logic [3:0] SBDP_FDIV_0 = 4'h1;
   localparam logic [3:0] SBDP_FDIV_1 = 4'h3;
   localparam logic [3:0] SBDP_FDIV_2 = 4'h4;
   localparam logic [3:0] SBDP_FDIV_3 = 4'hD;

   // ****************************************************************
   // status fields
   // ****************************************************************
   localparam int SBDP_ST_RXFULL  = 0;
   localparam int SBDP_ST_TXEMPTY = 1;
   localparam int SBDP_ST_FRAME   = 2;
   localparam int SBDP_ST_OVERRUN = 3;
   localparam int SBDP_ST_TXBUSY  = 4;

   // ****************************************************************
   // reset values and counts
   // ****************************************************************
   localparam logic [1:0] SBDP_FSEL_RST = 2'h0;
   localparam logic [7:0] SBDP_FINE_RST = 8'h00;
   localparam logic [3:0] SBDP_OVS_LAST = 4'hF;
   localparam logic [3:0] SBDP_OVS_MID  = 4'h7;
   localparam logic [3:0] SBDP_TX_LAST  = 4'h9;
   localparam logic [2:0] SBDP_RX_LAST  = 3'h7;
   localparam int         SBDP_RATE_W   = 20;

   typedef enum logic {SBDP_TX_IDLE, SBDP_TX_SHIFT} sbdp_tx_state_t;
   typedef enum logic [1:0] {
      SBDP_RX_IDLE, SBDP_RX_START, SBDP_RX_DATA, SBDP_RX_STOP
   } sbdp_rx_state_t;

endpackage

//--- rtl/sbdp_baud_data.sv
// serial baud generator and data path: holding buffers, shifters, rate chain.
// assumes a classic wishbone master on clk_i and an 8N1 remote transceiver.
`timescale 1ns/1ps

// ********************************************************************
// rate generator: one oversampling tick per full division
// ********************************************************************
module sbdp_rate_gen
   import sbdp_pkg::*;
(
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic       run_i,
   input  wire logic [1:0] fsel_i,
   input  wire logic [2:0] code_i,
   input  wire logic [7:0] fine_i,
   output logic            tick_o
);
   logic [3:0]             fdiv;
   logic [7:0]             fine_eff;
   logic [12:0]            base;
   logic [SBDP_RATE_W-1:0] limit;
   logic [SBDP_RATE_W-1:0] cnt_r;
   always_comb begin
      case (fsel_i)
         2'h0:    fdiv = SBDP_FDIV_0;
         2'h1:    fdiv = SBDP_FDIV_1;
         2'h2:    fdiv = SBDP_FDIV_2;
         default: fdiv = SBDP_FDIV_3;
      endcase
      // zero selects bypass, so the product never collapses to zero
      fine_eff = (fine_i == 8'h00) ? 8'h01 : fine_i;
      base     = 13'(fdiv) * 13'(fine_eff);
      limit    = SBDP_RATE_W'(base) << code_i;
   end
   always_ff @(posedge clk_i) begin
      if (rst_i || !run_i) begin
         cnt_r  <= '0;
         tick_o <= 1'b0;
      end else if (cnt_r >= limit - SBDP_RATE_W'(1)) begin
         cnt_r  <= '0;
         tick_o <= 1'b1;
      end else begin
         cnt_r  <= cnt_r + SBDP_RATE_W'(1);
         tick_o <= 1'b0;
      end
   end
endmodule // sbdp_rate_gen

// ********************************************************************
// top
// ********************************************************************
module sbdp_baud_data
   import sbdp_pkg::*;
(
   input  wire logic                          clk_i,
   input  wire logic                          rst_i,
   input  wire logic                          wb_cyc_i,
   input  wire logic                          wb_stb_i,
   input  wire logic                          wb_we_i,
   input  wire logic [sbdp_pkg::SBDP_ADR_W-1:0] wb_adr_i,
   input  wire logic [3:0]                    wb_sel_i,
   input  wire logic [31:0]                   wb_dat_i,
   output logic      [31:0]                   wb_dat_o,
   output logic                               wb_ack_o,
   input  wire logic                          rxd_i,
   output logic                               txd_o
);
   import sbdp_pkg::*;
   logic           acc;
   logic           wr;
   logic           rd;
   logic [7:0]     idx;
   logic [1:0]     first_stage_select_r;
   logic [2:0]     tx_divisor_code_r;
   logic [2:0]     rx_divisor_code_r;
   logic           codes_set_r;
   logic [7:0]     tx_fine_divider_r;
   logic [7:0]     rx_fine_divider_r;
   logic [7:0]     tx_holding_buffer_r;
   logic [7:0]     rx_holding_buffer_r;
   logic           tx_full_r;
   logic           rx_full_r;
   logic           overrun_r;
   logic           frame_err_r;
   logic           status_seen_r;
   logic           tx_tick;
   logic           rx_tick;
   sbdp_tx_state_t tx_state_r;
   logic [3:0]     tx_sub_r;
   logic [3:0]     tx_bits_r;
   logic [8:0]     tx_shift_r;
   logic           tx_load;
   sbdp_rx_state_t rx_state_r;
   logic [3:0]     rx_sub_r;
   logic [2:0]     rx_bits_r;
   logic [7:0]     rx_shift_r;
   logic           rx_meta_r;
   logic           rx_sync_r;
   logic           rx_load;
   logic [7:0]     status;
   logic [7:0]     rd_val;
   // ****************************************************************
   // wishbone decode: ack one cycle after the strobe is seen
   // ****************************************************************
   assign acc = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign wr  = acc && wb_we_i && wb_sel_i[0];
   assign rd  = acc && !wb_we_i;
   assign idx = wb_adr_i[SBDP_ADR_W-1:2];
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= acc;
      end
   end
   assign status = {3'h0, (tx_state_r == SBDP_TX_SHIFT), overrun_r, frame_err_r,
                    !tx_full_r, rx_full_r};
   always_comb begin
      case (idx)
         SBDP_IDX_STATUS: rd_val = status;
         SBDP_IDX_DATA:   rd_val = rx_holding_buffer_r;
         SBDP_IDX_BAUD:   rd_val = {first_stage_select_r, tx_divisor_code_r, rx_divisor_code_r};
         SBDP_IDX_RXFINE: rd_val = rx_fine_divider_r;
         SBDP_IDX_TXFINE: rd_val = tx_fine_divider_r;
         default:         rd_val = 8'h00;
      endcase
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_dat_o <= 32'h0000_0000;
      end else if (rd) begin
         wb_dat_o <= {24'h00_0000, rd_val};
      end
   end
   // ****************************************************************
   // rate registers
   // ****************************************************************
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         first_stage_select_r <= SBDP_FSEL_RST;
         codes_set_r          <= 1'b0;
      end else if (wr && idx == SBDP_IDX_BAUD) begin
         first_stage_select_r <= wb_dat_i[SBDP_FSEL_HI:SBDP_FSEL_LO];
         codes_set_r          <= 1'b1;   // rate chain waits for real codes
      end
   end
   // divisor codes carry no reset value
   always_ff @(posedge clk_i) begin
      if (wr && idx == SBDP_IDX_BAUD) begin
         tx_divisor_code_r <= wb_dat_i[SBDP_TXC_HI:SBDP_TXC_LO];
         rx_divisor_code_r <= wb_dat_i[SBDP_RXC_HI:SBDP_RXC_LO];
      end
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rx_fine_divider_r <= SBDP_FINE_RST;
         tx_fine_divider_r <= SBDP_FINE_RST;
      end else if (wr && idx == SBDP_IDX_RXFINE) begin
         rx_fine_divider_r <= wb_dat_i[7:0];
      end else if (wr && idx == SBDP_IDX_TXFINE) begin
         tx_fine_divider_r <= wb_dat_i[7:0];
      end
   end
   // ****************************************************************
   // independent rate chains
   // ****************************************************************
   sbdp_rate_gen u_tx_rate (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .run_i  (codes_set_r),
      .fsel_i (first_stage_select_r),
      .code_i (tx_divisor_code_r),
      .fine_i (tx_fine_divider_r),
      .tick_o (tx_tick)
   );
   sbdp_rate_gen u_rx_rate (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .run_i  (codes_set_r),
      .fsel_i (first_stage_select_r),
      .code_i (rx_divisor_code_r),
      .fine_i (rx_fine_divider_r),
      .tick_o (rx_tick)
   );
   // ****************************************************************
   // transmit holding buffer and shifter
   // ****************************************************************
   // no reset: content is undefined until software writes it
   always_ff @(posedge clk_i) begin
      if (wr && idx == SBDP_IDX_DATA) begin
         tx_holding_buffer_r <= wb_dat_i[7:0];
      end
   end
   assign tx_load = (tx_state_r == SBDP_TX_IDLE) && tx_full_r && tx_tick;
   // a write in the load cycle wins, so the new character is kept
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tx_full_r <= 1'b0;
      end else if (wr && idx == SBDP_IDX_DATA) begin
         tx_full_r <= 1'b1;
      end else if (tx_load) begin
         tx_full_r <= 1'b0;
      end
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tx_state_r <= SBDP_TX_IDLE;
         tx_sub_r   <= 4'h0;
         tx_bits_r  <= 4'h0;
         tx_shift_r <= 9'h1FF;
         txd_o      <= 1'b1;
      end else begin
         case (tx_state_r)
            SBDP_TX_IDLE: begin
               txd_o <= 1'b1;
               if (tx_load) begin
                  tx_shift_r <= {1'b1, tx_holding_buffer_r};
                  txd_o      <= 1'b0;
                  tx_sub_r   <= 4'h0;
                  tx_bits_r  <= 4'h0;
                  tx_state_r <= SBDP_TX_SHIFT;
               end
            end
            SBDP_TX_SHIFT: begin
               if (tx_tick) begin
                  tx_sub_r <= tx_sub_r + 4'h1;
                  if (tx_sub_r == SBDP_OVS_LAST) begin
                     if (tx_bits_r == SBDP_TX_LAST) begin
                        tx_state_r <= SBDP_TX_IDLE;
                     end else begin
                        txd_o      <= tx_shift_r[0];
                        tx_shift_r <= {1'b1, tx_shift_r[8:1]};
                        tx_bits_r  <= tx_bits_r + 4'h1;
                     end
                  end
               end
            end
            default: tx_state_r <= SBDP_TX_IDLE;
         endcase
      end
   end

   // ****************************************************************
   // receive line synchroniser and shifter
   // ****************************************************************
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rx_meta_r <= 1'b1;
         rx_sync_r <= 1'b1;
      end else begin
         rx_meta_r <= rxd_i;
         rx_sync_r <= rx_meta_r;
      end
   end
   assign rx_load = (rx_state_r == SBDP_RX_STOP) && rx_tick && (rx_sub_r == SBDP_OVS_LAST);
   // start is checked at mid bit, data and stop one full bit later each
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rx_state_r <= SBDP_RX_IDLE;
         rx_sub_r   <= 4'h0;
         rx_bits_r  <= 3'h0;
         rx_shift_r <= 8'h00;
      end else begin
         case (rx_state_r)
            SBDP_RX_IDLE: begin
               rx_sub_r <= 4'h0;
               if (rx_tick && !rx_sync_r) begin
                  rx_state_r <= SBDP_RX_START;
               end
            end
            SBDP_RX_START: begin
               if (rx_tick) begin
                  rx_sub_r <= rx_sub_r + 4'h1;
                  if (rx_sub_r == SBDP_OVS_MID) begin
                     rx_sub_r   <= 4'h0;
                     rx_bits_r  <= 3'h0;
                     rx_state_r <= rx_sync_r ? SBDP_RX_IDLE : SBDP_RX_DATA;
                  end
               end
            end
            SBDP_RX_DATA: begin
               if (rx_tick) begin
                  rx_sub_r <= rx_sub_r + 4'h1;
                  if (rx_sub_r == SBDP_OVS_LAST) begin
                     rx_shift_r <= {rx_sync_r, rx_shift_r[7:1]};
                     rx_bits_r  <= rx_bits_r + 3'h1;
                     if (rx_bits_r == SBDP_RX_LAST) begin
                        rx_state_r <= SBDP_RX_STOP;
                     end
                  end
               end
            end
            SBDP_RX_STOP: begin
               if (rx_tick) begin
                  rx_sub_r <= rx_sub_r + 4'h1;
                  if (rx_sub_r == SBDP_OVS_LAST) begin
                     rx_state_r <= SBDP_RX_IDLE;
                  end
               end
            end
            default: rx_state_r <= SBDP_RX_IDLE;
         endcase
      end
   end

   // overrun keeps the buffered word; only the shifter is lost
   always_ff @(posedge clk_i) begin
      if (rx_load && !rx_full_r) begin
         rx_holding_buffer_r <= rx_shift_r;
      end
   end
   // ****************************************************************
   // receive flags; a set in the clearing cycle wins
   // ****************************************************************
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rx_full_r     <= 1'b0;
         overrun_r     <= 1'b0;
         frame_err_r   <= 1'b0;
         status_seen_r <= 1'b0;
      end else begin
         if (acc && idx == SBDP_IDX_STATUS) begin
            status_seen_r <= 1'b1;
         end
         if (rd && idx == SBDP_IDX_DATA) begin
            rx_full_r <= 1'b0;
            if (status_seen_r) begin
               overrun_r     <= 1'b0;
               frame_err_r   <= 1'b0;
               status_seen_r <= 1'b0;
            end
         end
         if (rx_load) begin
            if (rx_full_r) begin
               overrun_r <= 1'b1;
            end else begin
               rx_full_r   <= 1'b1;
               if (!rx_sync_r) begin
                  frame_err_r <= 1'b1;
               end
            end
         end
      end
   end

endmodule // sbdp_baud_data

//--- tb/sbdp_chk_sva.sv
// assertion checker for the serial baud and data path top ports
// assumes it is bound to sbdp_baud_data and sees only its ports
`timescale 1ns/1ps
module sbdp_chk
   import sbdp_pkg::*;
(
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [9:0]  wb_adr_i,
   input wire logic [3:0]  wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   input wire logic        rxd_i,
   input wire logic        txd_o
);
   // ****************************************************************
   // shadow of the fine dividers and first stage select
   // ****************************************************************
   logic [7:0] rxf_r;
   logic [7:0] txf_r;
   logic [1:0] fsel_r;
   logic [7:0] idx;
   logic       mapped;
   logic       wr_take;
   logic       rd_take;
   assign idx     = wb_adr_i[9:2];
   assign mapped  = idx inside {SBDP_IDX_STATUS, SBDP_IDX_DATA, SBDP_IDX_BAUD,
                                SBDP_IDX_RXFINE, SBDP_IDX_TXFINE};
   assign wr_take = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[0];
   assign rd_take = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rxf_r  <= SBDP_FINE_RST;
         txf_r  <= SBDP_FINE_RST;
         fsel_r <= SBDP_FSEL_RST;
      end else if (wr_take) begin
         if (idx == SBDP_IDX_RXFINE) rxf_r <= wb_dat_i[7:0];
         if (idx == SBDP_IDX_TXFINE) txf_r <= wb_dat_i[7:0];
         if (idx == SBDP_IDX_BAUD) fsel_r <= wb_dat_i[7:6];
      end
   end

   // ****************************************************************
   // assertions
   // ****************************************************************
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("request not acked next cycle");
   AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   AST_ACK_CAUSE: assert property (wb_ack_o |-> $past(wb_stb_i))
      else $error("ack without request");
   AST_RXFINE_RD: assert property (wb_ack_o && !$past(wb_we_i) && $past(idx) == SBDP_IDX_RXFINE
      |-> wb_dat_o == {24'h000000, rxf_r})
      else $error("rx fine readback wrong");
   AST_TXFINE_RD: assert property (wb_ack_o && !$past(wb_we_i) && $past(idx) == SBDP_IDX_TXFINE
      |-> wb_dat_o == {24'h000000, txf_r})
      else $error("tx fine readback wrong");
   AST_FSEL_RD: assert property (wb_ack_o && !$past(wb_we_i) && $past(idx) == SBDP_IDX_BAUD
      |-> wb_dat_o[7:6] == fsel_r)
      else $error("first stage select readback wrong");
   AST_UNMAPPED: assert property (wb_ack_o && !$past(wb_we_i) && !$past(mapped)
      |-> wb_dat_o == 32'h00000000)
      else $error("unmapped read not zero");
   AST_DAT_HOLD: assert property (!rd_take |=> $stable(wb_dat_o))
      else $error("read data changed without a read");
   AST_TXD_RST: assert property ($fell(rst_i) |-> txd_o && !wb_ack_o)
      else $error("line not idle after reset");
   AST_START_MIN: assert property ($fell(txd_o) |-> (!txd_o)[*8])
      else $error("serial bit shorter than minimum");
endmodule // sbdp_chk

bind sbdp_baud_data sbdp_chk u_chk (
   .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rxd_i(rxd_i), .txd_o(txd_o)
);

//--- tb/sbdp_remote_model.sv
// remote 8N1 transceiver model facing the serial pins
// assumes bit lengths in bus clocks are set by the bench
`timescale 1ns/1ps
module sbdp_remote_model (
   input  wire logic        clk_i,
   input  wire logic        txd_i,
   input  wire logic [15:0] tx_bit_i,
   input  wire logic [15:0] rx_bit_i,
   output logic             rxd_o,
   output logic [7:0]       got_byte_o,
   output logic [7:0]       got_cnt_o
);
   // ****************************************************************
   // line driver and sampler
   // ****************************************************************
   initial begin
      rxd_o      = 1'h1;
      got_byte_o = 8'h00;
      got_cnt_o  = 8'h00;
   end
   task automatic wait_clks(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   // bad stop is low only part of the bit so no false start follows
   task automatic send_byte(input logic [7:0] b, input logic bad_stop);
      int i;
      @(posedge clk_i) rxd_o <= 1'h0;
      wait_clks(rx_bit_i);
      for (i = 0; i < 8; i++) begin
         rxd_o <= b[i];
         wait_clks(rx_bit_i);
      end
      rxd_o <= ~bad_stop;
      wait_clks(bad_stop ? rx_bit_i * 5 / 8 : rx_bit_i);
      rxd_o <= 1'h1;
      if (bad_stop) wait_clks(rx_bit_i - rx_bit_i * 5 / 8);
   endtask
   initial begin : sampler
      logic [7:0] sh;
      int         i;
      sh = 8'h00;
      forever begin
         @(negedge txd_i);
         wait_clks(tx_bit_i / 2);
         for (i = 0; i < 8; i++) begin
            wait_clks(tx_bit_i);
            sh[i] = txd_i;
         end
         wait_clks(tx_bit_i);
         if (txd_i === 1'h1) begin
            got_byte_o <= sh;
            got_cnt_o  <= got_cnt_o + 8'h01;
         end
      end
   end
endmodule // sbdp_remote_model

//--- tb/tb.sv
// self-checking bench for the serial baud and data path
// assumes the design, its bound checker and the remote model
`timescale 1ns/1ps
module tb;
   import sbdp_pkg::*;
   typedef struct packed {
      logic [7:0]  baud, tfine, rfine, data;
      logic [15:0] tbit, rbit;
   } sbdp_row_t;
   logic        clk_i, rst_i, wb_cyc, wb_stb, wb_we, wb_ack, txd, rxd;
   logic [9:0]  wb_adr;
   logic [3:0]  wb_sel;
   logic [31:0] wb_dat, wb_dat_o;
   logic [15:0] tx_bit, rx_bit;
   logic [7:0]  got_byte, got_cnt;
   int          mismatches, checks_done;
   sbdp_row_t   rows [7];

   sbdp_baud_data dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
      .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack), .rxd_i(rxd), .txd_o(txd));
   sbdp_remote_model u_remote (.clk_i(clk_i), .txd_i(txd), .tx_bit_i(tx_bit),
      .rx_bit_i(rx_bit), .rxd_o(rxd), .got_byte_o(got_byte), .got_cnt_o(got_cnt));

   // ****************************************************************
   // bus cycles, comparison and verdict
   // ****************************************************************
   task automatic wb_bus(input logic we, input logic [7:0] idx, input logic [7:0] d,
                         input logic [3:0] sel, output logic [31:0] q);
      wb_cyc <= 1'h1;
      wb_stb <= 1'h1;
      wb_we  <= we;
      wb_adr <= {idx, 2'h0};
      wb_sel <= sel;
      wb_dat <= {24'h000000, d};
      @(posedge clk_i);
      while (wb_ack !== 1'h1) @(posedge clk_i);
      q = wb_dat_o;
      wb_cyc <= 1'h0;
      wb_stb <= 1'h0;
      @(posedge clk_i);
   endtask
   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      logic [31:0] q;
      wb_bus(1'h1, idx, d, 4'hF, q);
   endtask
   task automatic rd(input logic [7:0] idx, output logic [31:0] q);
      wb_bus(1'h0, idx, 8'h00, 4'hF, q);
   endtask
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic summarize;
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   initial begin
      clk_i = 1'h0;
      forever #25 clk_i = ~clk_i;
   end
   initial begin
      repeat (100000) @(posedge clk_i);
      mismatches++;
      summarize;
   end

   // ****************************************************************
   // rate table, then reset and awkward cases
   // ****************************************************************
   initial begin : main
      sbdp_row_t   r;
      logic [31:0] q;
      logic [7:0]  c0;
      int          n;
      // rates fall row by row so no divider is caught past a new limit
      rows = '{'{8'h00, 8'h00, 8'h00, 8'hA5, 16'h0010, 16'h0010},
               '{8'h40, 8'h00, 8'h00, 8'h5B, 16'h0030, 16'h0030},
               '{8'h80, 8'h00, 8'h00, 8'h81, 16'h0040, 16'h0040},
               '{8'h08, 8'h03, 8'h05, 8'h69, 16'h0060, 16'h0050},
               '{8'hC0, 8'h00, 8'h00, 8'h7F, 16'h00D0, 16'h00D0},
               '{8'h34, 8'h00, 8'h00, 8'hC3, 16'h0400, 16'h0100},
               '{8'h00, 8'hFF, 8'h11, 8'hD5, 16'h0FF0, 16'h0110}};
      {rst_i, wb_cyc, wb_stb, wb_we, wb_adr, wb_sel, wb_dat} = {1'h1, 49'h0};
      tx_bit = 16'h0010;
      rx_bit = 16'h0010;
      mismatches = 0;
      checks_done = 0;
      repeat (8) @(posedge clk_i);
      rst_i <= 1'h0;
      foreach (rows[i]) begin
         r = rows[i];
         wr(SBDP_IDX_BAUD, r.baud);
         wr(SBDP_IDX_RXFINE, r.rfine);
         wr(SBDP_IDX_TXFINE, r.tfine);
         tx_bit <= r.tbit;
         rx_bit <= r.rbit;
         c0 = got_cnt;
         wr(SBDP_IDX_DATA, r.data);
         n = 0;
         while (txd !== 1'h0) @(posedge clk_i);
         while (txd === 1'h0) begin
            @(posedge clk_i);
            n++;
         end
         check("tx bit clocks", 32'(n), {16'h0000, r.tbit});
         while (got_cnt == c0) @(posedge clk_i);
         check("tx byte", {24'h000000, got_byte}, {24'h000000, r.data});
         u_remote.send_byte(~r.data, 1'h0);
         rd(SBDP_IDX_STATUS, q);
         check("rx status", q & 32'h0000000D, 32'h00000001);
         rd(SBDP_IDX_DATA, q);
         check("rx byte", q, {24'h000000, ~r.data});
         $display("row %0d done", i);
      end
      wr(SBDP_IDX_BAUD, 8'hFF);
      rst_i <= 1'h1;
      repeat (8) @(posedge clk_i);
      rst_i <= 1'h0;
      check("txd idle", {31'h0, txd}, 32'h00000001);
      rd(SBDP_IDX_RXFINE, q);
      check("rx fine reset", q, 32'h00000000);
      rd(SBDP_IDX_TXFINE, q);
      check("tx fine reset", q, 32'h00000000);
      rd(SBDP_IDX_BAUD, q);
      check("first stage reset", q & 32'h000000C0, 32'h00000000);
      $display("reset test done");
      wr(SBDP_IDX_BAUD, 8'h00);
      tx_bit <= 16'h0010;
      rx_bit <= 16'h0010;
      u_remote.send_byte(8'h3A, 1'h1);
      rd(SBDP_IDX_DATA, q);
      check("bad frame byte", q, 32'h0000003A);
      rd(SBDP_IDX_STATUS, q);
      check("framing kept", q & 32'h0000000D, 32'h00000004);
      rd(SBDP_IDX_DATA, q);
      rd(SBDP_IDX_STATUS, q);
      check("framing cleared", q & 32'h0000000D, 32'h00000000);
      $display("framing test done");
      u_remote.send_byte(8'h11, 1'h0);
      u_remote.send_byte(8'h22, 1'h0);
      rd(SBDP_IDX_STATUS, q);
      check("overrun set", q & 32'h0000000D, 32'h00000009);
      rd(SBDP_IDX_DATA, q);
      check("old word kept", q, 32'h00000011);
      rd(SBDP_IDX_STATUS, q);
      check("overrun cleared", q & 32'h0000000D, 32'h00000000);
      $display("overrun test done");
      wb_bus(1'h1, SBDP_IDX_TXFINE, 8'h44, 4'hE, q);
      rd(SBDP_IDX_TXFINE, q);
      check("unselected write", q, 32'h00000000);
      wr(8'h10, 8'h5A);
      rd(8'h10, q);
      check("unmapped read", q, 32'h00000000);
      $display("bus refusal test done");
      summarize;
   end
endmodule // tb
